// File: nvm_register_bank.sv
// Purpose: Limit and scratch registers with NVM backing, plus an offset register without
// Assumes: Link side on lk_clk, bank and result path on clk
// Notes: Link accesses cross by a toggle handshake with held words
`timescale 1ns/1ps
module nvm_register_bank #(
	parameter int unsigned PROG_CYCLES = nvm_bank_pkg::PROG_CYCLES,
	parameter logic [15:0] UID_A = 16'h1234, // Arbitrary identifier value
	parameter logic [15:0] UID_C = 16'h5678 // Arbitrary identifier value
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic lk_clk,
	input wire logic lk_wr,
	input wire logic lk_rd,
	input wire logic [7:0] lk_addr,
	input wire logic [15:0] lk_wdata,
	output logic lk_pending,
	output logic lk_done,
	output logic [15:0] lk_rdata,
	input wire logic factory_load,
	input wire logic raw_valid,
	input wire logic [15:0] raw_result,
	input wire logic therm_mode,
	input wire logic flag_clear,
	output logic result_valid,
	output logic [15:0] temp_result,
	output logic high_alert,
	output logic low_alert,
	output logic nvm_busy,
	output logic nvm_write_unlock,
	output logic [15:0] high_limit,
	output logic [15:0] low_limit
);
	// Map a register pointer to its NVM slot
	function automatic logic [2:0] slot_of(input logic [7:0] a);
		unique case (a)
			nvm_bank_pkg::ADDR_HIGH: slot_of = nvm_bank_pkg::SLOT_HIGH;
			nvm_bank_pkg::ADDR_LOW: slot_of = nvm_bank_pkg::SLOT_LOW;
			nvm_bank_pkg::ADDR_SCR_A: slot_of = nvm_bank_pkg::SLOT_SCR_A;
			nvm_bank_pkg::ADDR_SCR_B: slot_of = nvm_bank_pkg::SLOT_SCR_B;
			nvm_bank_pkg::ADDR_SCR_C: slot_of = nvm_bank_pkg::SLOT_SCR_C;
			default: slot_of = nvm_bank_pkg::SLOT_NONE;
		endcase
	endfunction

	// Link-side state
	typedef struct packed {
		nvm_bank_pkg::link_req_s req;
		logic req_tgl;
		logic ack_s1;
		logic ack_s2;
		logic ack_s3;
		logic pending;
		logic done;
		logic [15:0] rdata;
	} lk_state_s;

	// Bank-side state
	typedef struct packed {
		nvm_bank_pkg::nvm_state_e st;
		logic [2:0] ld_idx;
		logic [nvm_bank_pkg::CNT_W-1:0] cnt;
		logic req_s1;
		logic req_s2;
		logic req_s3;
		logic ack_tgl;
		logic [15:0] ans;
		logic [15:0] high;
		logic [15:0] low;
		logic [15:0] scr_a;
		logic [15:0] scr_b;
		logic [15:0] scr_c;
		logic [15:0] offset;
		logic unlock;
		logic rvalid;
		logic [15:0] result;
		logic hi_flag;
		logic lo_flag;
	} bk_state_s;

	lk_state_s lq, ld;
	bk_state_s bq, bd;
	// Non-volatile words; they survive rstn, only factory_load presets them
	logic [15:0] nvm_mem [nvm_bank_pkg::NVM_SLOTS];
	logic nvm_we;
	logic [2:0] nvm_wslot;
	logic [15:0] nvm_wdata;
	// Helper views used by the bank logic
	logic req_new;
	logic [2:0] req_slot;
	logic [16:0] sum;
	logic [15:0] corr;
	logic busy;

	// Link side: take a request only when none is in flight
	always_comb begin
		ld = lq;
		ld.done = 1'b0;
		ld.ack_s1 = bq.ack_tgl;
		ld.ack_s2 = lq.ack_s1;
		ld.ack_s3 = lq.ack_s2;
		if (lq.pending && (lq.ack_s2 != lq.ack_s3)) begin
			// Answer word is stable: bank holds it until the next request
			ld.rdata = bq.ans;
			ld.pending = 1'b0;
			ld.done = 1'b1;
		end else if (!lq.pending && (lk_wr || lk_rd)) begin
			// Write wins if both strobes come together
			ld.req.wr = lk_wr;
			ld.req.addr = lk_addr;
			ld.req.data = lk_wdata;
			ld.req_tgl = ~lq.req_tgl;
			ld.pending = 1'b1;
		end
	end

	// Link-side register
	always_ff @(posedge lk_clk or negedge rstn) begin
		if (!rstn) begin
			lq <= '0;
		end else begin
			lq <= ld;
		end
	end

	assign lk_pending = lq.pending;
	assign lk_done = lq.done;
	assign lk_rdata = lq.rdata;

	// Bank-side helpers
	always_comb begin
		req_new = (bq.req_s2 != bq.req_s3);
		req_slot = slot_of(lq.req.addr);
		busy = (bq.st != nvm_bank_pkg::ST_IDLE);
		// Widened add so an overflow is visible as the top two bits differing
		sum = {raw_result[15], raw_result} + {bq.offset[15], bq.offset};
		if (sum[16] != sum[15]) begin
			corr = sum[16] ? nvm_bank_pkg::TEMP_MIN : nvm_bank_pkg::TEMP_MAX;
		end else begin
			corr = sum[15:0];
		end
	end

	// Bank side: load, register access, programming and result path
	always_comb begin
		bd = bq;
		nvm_we = 1'b0;
		nvm_wslot = req_slot;
		nvm_wdata = lq.req.data;
		bd.req_s1 = lq.req_tgl;
		bd.req_s2 = bq.req_s1;
		bd.req_s3 = bq.req_s2;
		bd.rvalid = 1'b0;
		unique case (bq.st)
			nvm_bank_pkg::ST_LOAD: begin
				// Copy one NVM word per cycle into its register
				unique case (bq.ld_idx)
					nvm_bank_pkg::SLOT_HIGH: bd.high = nvm_mem[0];
					nvm_bank_pkg::SLOT_LOW: bd.low = nvm_mem[1];
					nvm_bank_pkg::SLOT_SCR_A: bd.scr_a = nvm_mem[2];
					nvm_bank_pkg::SLOT_SCR_B: bd.scr_b = nvm_mem[3];
					default: bd.scr_c = nvm_mem[4];
				endcase
				if (bq.ld_idx == nvm_bank_pkg::SLOT_SCR_C) begin
					bd.st = nvm_bank_pkg::ST_IDLE;
				end else begin
					bd.ld_idx = bq.ld_idx + 3'h1;
				end
			end
			nvm_bank_pkg::ST_PROG: begin
				// Hold busy for the programming time
				if (bq.cnt == '0) begin
					bd.st = nvm_bank_pkg::ST_IDLE;
				end else begin
					bd.cnt = bq.cnt - 1'b1;
				end
			end
			default: begin
			end
		endcase
		if (req_new) begin
			if (lq.req.wr) begin
				// Unlocked writes to backed words during busy are dropped
				if (!(bq.unlock && busy && req_slot != nvm_bank_pkg::SLOT_NONE)) begin
					unique case (lq.req.addr)
						nvm_bank_pkg::ADDR_HIGH: bd.high = lq.req.data;
						nvm_bank_pkg::ADDR_LOW: bd.low = lq.req.data;
						nvm_bank_pkg::ADDR_UNLOCK: bd.unlock = lq.req.data[nvm_bank_pkg::UNLOCK_BIT];
						nvm_bank_pkg::ADDR_SCR_A: bd.scr_a = lq.req.data;
						nvm_bank_pkg::ADDR_SCR_B: bd.scr_b = lq.req.data;
						nvm_bank_pkg::ADDR_OFFSET: bd.offset = lq.req.data;
						nvm_bank_pkg::ADDR_SCR_C: bd.scr_c = lq.req.data;
						default: begin
						end
					endcase
					// Locked writes never reach the NVM
					if (bq.unlock && req_slot != nvm_bank_pkg::SLOT_NONE) begin
						nvm_we = 1'b1;
						bd.st = nvm_bank_pkg::ST_PROG;
						bd.cnt = (nvm_bank_pkg::CNT_W)'(PROG_CYCLES - 1);
					end
				end
				bd.ans = '0;
			end else begin
				// Read answer; unmapped pointers read zero
				unique case (lq.req.addr)
					nvm_bank_pkg::ADDR_HIGH: bd.ans = bq.high;
					nvm_bank_pkg::ADDR_LOW: bd.ans = bq.low;
					nvm_bank_pkg::ADDR_UNLOCK: bd.ans = {bq.unlock, busy, 14'h0000};
					nvm_bank_pkg::ADDR_SCR_A: bd.ans = bq.scr_a;
					nvm_bank_pkg::ADDR_SCR_B: bd.ans = bq.scr_b;
					nvm_bank_pkg::ADDR_OFFSET: bd.ans = bq.offset;
					nvm_bank_pkg::ADDR_SCR_C: bd.ans = bq.scr_c;
					default: bd.ans = '0;
				endcase
			end
			bd.ack_tgl = ~bq.ack_tgl;
		end
		// Corrected result and alert flags; a set beats a same-cycle clear
		if (flag_clear) begin
			bd.hi_flag = 1'b0;
			bd.lo_flag = 1'b0;
		end
		if (raw_valid) begin
			bd.rvalid = 1'b1;
			bd.result = corr;
			if (!therm_mode && $signed(corr) > $signed(bq.high)) begin
				bd.hi_flag = 1'b1;
			end
			if (!therm_mode && $signed(corr) < $signed(bq.low)) begin
				bd.lo_flag = 1'b1;
			end
		end
	end

	// Bank-side register; the load starts straight after reset release
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bq <= '0;
			bq.st <= nvm_bank_pkg::ST_LOAD;
			bq.unlock <= nvm_bank_pkg::RST_UNLOCK[nvm_bank_pkg::UNLOCK_BIT];
			bq.offset <= nvm_bank_pkg::RST_OFFSET;
			bq.low <= nvm_bank_pkg::FACTORY_LOW;
			bq.high <= nvm_bank_pkg::FACTORY_HIGH;
		end else begin
			bq <= bd;
		end
	end

	// NVM array; factory_load stands for manufacture-time programming
	always_ff @(posedge clk) begin
		if (factory_load) begin
			nvm_mem[0] <= nvm_bank_pkg::FACTORY_HIGH;
			nvm_mem[1] <= nvm_bank_pkg::FACTORY_LOW;
			nvm_mem[2] <= UID_A;
			nvm_mem[3] <= nvm_bank_pkg::FACTORY_SCR_B;
			nvm_mem[4] <= UID_C;
		end else if (nvm_we) begin
			nvm_mem[nvm_wslot] <= nvm_wdata;
		end
	end

	assign result_valid = bq.rvalid;
	assign temp_result = bq.result;
	assign high_alert = bq.hi_flag;
	assign low_alert = bq.lo_flag;
	assign nvm_busy = busy;
	assign nvm_write_unlock = bq.unlock;
	assign high_limit = bq.high;
	assign low_limit = bq.low;

	// Checks on the bank side
	a_busy_mirror: assert property (@(posedge clk) disable iff (!rstn)
		(req_new && !lq.req.wr && lq.req.addr == nvm_bank_pkg::ADDR_UNLOCK)
		|=> bq.ans[nvm_bank_pkg::BUSY_BIT] == $past(nvm_busy))
		else $error("busy mirror wrong");

	a_prog_start: assert property (@(posedge clk) disable iff (!rstn)
		(req_new && lq.req.wr && bq.unlock && !busy && req_slot != nvm_bank_pkg::SLOT_NONE)
		|=> nvm_busy && nvm_mem[$past(req_slot)] == $past(lq.req.data))
		else $error("unlocked write did not program");

	a_lock_hold: assert property (@(posedge clk) disable iff (!rstn || factory_load)
		(req_new && lq.req.wr && !bq.unlock && req_slot != nvm_bank_pkg::SLOT_NONE)
		|=> $stable(nvm_mem[$past(req_slot)]))
		else $error("locked write changed nvm");

	a_load_low: assert property (@(posedge clk) disable iff (!rstn)
		(bq.st == nvm_bank_pkg::ST_LOAD && bd.st == nvm_bank_pkg::ST_IDLE)
		|=> low_limit == nvm_mem[1])
		else $error("low threshold not loaded");

	a_sat_high: assert property (@(posedge clk) disable iff (!rstn)
		(raw_valid && !sum[16] && sum[15]) |=> temp_result == 16'h7FFF)
		else $error("positive overflow not saturated");

	a_sat_low: assert property (@(posedge clk) disable iff (!rstn)
		(raw_valid && sum[16] && !sum[15]) |=> temp_result == 16'h8000)
		else $error("negative overflow not saturated");

	a_high_flag: assert property (@(posedge clk) disable iff (!rstn)
		(raw_valid && !therm_mode && $signed(corr) > $signed(high_limit))
		|=> high_alert ##1 (high_alert || $past(flag_clear)))
		else $error("high alert missed");

	a_low_flag: assert property (@(posedge clk) disable iff (!rstn)
		(raw_valid && !therm_mode && $signed(corr) < $signed(low_limit)) |=> low_alert)
		else $error("low alert missed");

	a_prog_len: assert property (@(posedge clk) disable iff (!rstn)
		$rose(bq.st == nvm_bank_pkg::ST_PROG) |-> nvm_busy [*8])
		else $error("busy dropped early");
endmodule

// File: nvm_bank_pkg.sv
// Purpose: Constants and types for the limit, offset and NVM register bank
// Assumes: 16-bit registers, byte register pointer from the serial link
// Notes: Register map, NVM slots, programming time and types are listed below
package nvm_bank_pkg;
	localparam logic [7:0] ADDR_HIGH = 8'h02;
	localparam logic [7:0] ADDR_LOW = 8'h03;
	localparam logic [7:0] ADDR_UNLOCK = 8'h04;
	localparam logic [7:0] ADDR_SCR_A = 8'h05;
	localparam logic [7:0] ADDR_SCR_B = 8'h06;
	localparam logic [7:0] ADDR_OFFSET = 8'h07;
	localparam logic [7:0] ADDR_SCR_C = 8'h08;
	localparam int UNLOCK_BIT = 15;
	localparam int BUSY_BIT = 14;
	localparam logic [15:0] RST_UNLOCK = 16'h0000;
	localparam logic [15:0] RST_OFFSET = 16'h0000;
	localparam logic [15:0] FACTORY_HIGH = 16'h6000;
	localparam logic [15:0] FACTORY_LOW = 16'h8000;
	localparam logic [15:0] FACTORY_SCR_B = 16'h0000;
	localparam logic [15:0] TEMP_MAX = 16'h7FFF;
	localparam logic [15:0] TEMP_MIN = 16'h8000;
	// NVM slot numbers of the backed registers
	localparam logic [2:0] SLOT_HIGH = 3'h0;
	localparam logic [2:0] SLOT_LOW = 3'h1;
	localparam logic [2:0] SLOT_SCR_A = 3'h2;
	localparam logic [2:0] SLOT_SCR_B = 3'h3;
	localparam logic [2:0] SLOT_SCR_C = 3'h4;
	localparam logic [2:0] SLOT_NONE = 3'h7;
	localparam int NVM_SLOTS = 5;
	// Programming time and clock rate
	localparam int PROG_TIME_US = 7000;
	localparam int CLK_MHZ = 10;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int CNT_W = 24;
	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_IDLE = 2'b01,
		ST_PROG = 2'b10
	} nvm_state_e;
	// One register access as carried across the link crossing
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [15:0] data;
	} link_req_s;
endpackage

// File: link_host_model.sv
// Purpose: Host side of the register link, one request at a time
// Assumes: Strobes are one lk_clk pulse, answer marked by lk_done
// Notes: Released address and data lines show the inverse value
`timescale 1ns/1ps
module link_host_model (
	input wire logic lk_clk,
	output logic lk_wr,
	output logic lk_rd,
	output logic [7:0] lk_addr,
	output logic [15:0] lk_wdata,
	input wire logic lk_done,
	input wire logic [15:0] lk_rdata
);
	// Idle bus at time zero
	initial begin
		lk_wr = 1'b0;
		lk_rd = 1'b0;
		lk_addr = 8'h00;
		lk_wdata = 16'h0000;
	end

	// One transfer; ok stays low if no answer comes in the bound
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [15:0] data,
		output logic [15:0] rdata, output logic ok);
		ok = 1'b0;
		rdata = 16'h0000;
		@(posedge lk_clk);
		lk_wr <= wr;
		lk_rd <= !wr;
		lk_addr <= addr;
		lk_wdata <= data;
		@(posedge lk_clk);
		lk_wr <= 1'b0;
		lk_rd <= 1'b0;
		// Address and data held until the answer is taken
		for (int i = 0; i < 400 && !ok; i++) begin
			@(posedge lk_clk);
			if (lk_done === 1'b1) begin
				ok = 1'b1;
				rdata = lk_rdata;
			end
		end
		// Stale values would hide a late sample in the bank
		lk_addr <= ~addr;
		lk_wdata <= ~data;
	endtask
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench of the limit, offset and scratch bank
// Assumes: Short programming time so the run stays brief
// Notes: Expected values come from the register map, not the bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_top;
	localparam int unsigned PROG = 20;
	logic clk = 1'b0;
	logic lk_clk = 1'b0;
	logic rstn = 1'b0;
	logic factory_load = 1'b1;
	logic raw_valid = 1'b0;
	logic [15:0] raw_result = 16'h0000;
	logic flag_clear = 1'b0;
	logic therm_mode = 1'b0;
	logic lk_wr, lk_rd, lk_pending, lk_done, result_valid, high_alert, low_alert;
	logic nvm_busy, nvm_write_unlock;
	logic [7:0] lk_addr;
	logic [15:0] lk_wdata, lk_rdata, temp_result, high_limit, low_limit;
	int miscompares = 0;
	int n_tests = 0;

	// Bank clock 10 MHz, link clock 6 ns, no phase relation kept
	always #50 clk = ~clk;
	always #3 lk_clk = ~lk_clk;

	nvm_register_bank #(.PROG_CYCLES(PROG)) i_dut (.clk(clk), .rstn(rstn), .lk_clk(lk_clk),
		.lk_wr(lk_wr), .lk_rd(lk_rd), .lk_addr(lk_addr), .lk_wdata(lk_wdata),
		.lk_pending(lk_pending), .lk_done(lk_done), .lk_rdata(lk_rdata),
		.factory_load(factory_load), .raw_valid(raw_valid), .raw_result(raw_result),
		.therm_mode(therm_mode), .flag_clear(flag_clear), .result_valid(result_valid),
		.temp_result(temp_result), .high_alert(high_alert), .low_alert(low_alert),
		.nvm_busy(nvm_busy), .nvm_write_unlock(nvm_write_unlock),
		.high_limit(high_limit), .low_limit(low_limit));

	link_host_model host (.lk_clk(lk_clk), .lk_wr(lk_wr), .lk_rd(lk_rd), .lk_addr(lk_addr),
		.lk_wdata(lk_wdata), .lk_done(lk_done), .lk_rdata(lk_rdata));

	// Verdict and end of run
	task automatic final_report();
		if (miscompares == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// A bound that runs out ends the run as a failure
	task automatic timeout();
		miscompares++;
		final_report();
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] r;
		logic ok;
		host.xfer(1'b1, a, d, r, ok);
		if (!ok) timeout();
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] r;
		logic ok;
		host.xfer(1'b0, a, 16'h0000, r, ok);
		if (!ok) timeout();
		`CHK($sformatf("reg %h", a), e, r)
	endtask

	// Waits for the store to settle, bounded
	task automatic wait_idle();
		for (int i = 0; i < 200 && nvm_busy !== 1'b0; i++) @(posedge clk);
		if (nvm_busy !== 1'b0) timeout();
	endtask

	// Reset held 12 cycles; fl presets the store to factory content
	task automatic do_reset(input logic fl, input logic [15:0] lo);
		@(posedge clk);
		rstn <= 1'b0;
		factory_load <= fl;
		repeat (12) @(posedge clk);
		`CHK("busy in reset", 1'b1, nvm_busy)
		`CHK("low in reset", 16'h8000, low_limit)
		rstn <= 1'b1;
		factory_load <= 1'b0;
		wait_idle();
		`CHK("low loaded", lo, low_limit)
	endtask

	task automatic res(input logic [15:0] raw, input logic [15:0] e);
		@(posedge clk);
		raw_valid <= 1'b1;
		raw_result <= raw;
		@(posedge clk);
		raw_valid <= 1'b0;
		#1;
		`CHK("result_valid", 1'b1, result_valid)
		`CHK("temp_result", e, temp_result)
	endtask

	// Map after factory load, unmapped 0Ah included
	task automatic t_map();
		logic [7:0] ad[8] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A};
		logic [15:0] ex[8] = '{16'h6000, 16'h8000, 16'h0000, 16'h1234, 16'h0000, 16'h0000,
			16'h5678, 16'h0000};
		for (int i = 0; i < 8; i++) chk_rd(ad[i], ex[i]);
	endtask

	// Locked writes reach the registers only
	task automatic t_locked();
		wr(8'h03, 16'hFF00);
		`CHK("low_limit", 16'hFF00, low_limit)
		wr(8'h05, 16'hABCD);
		chk_rd(8'h05, 16'hABCD);
		do_reset(1'b0, 16'h8000);
		chk_rd(8'h05, 16'h1234);
	endtask

	// Unlocked writes program the store; word A is left alone
	task automatic t_unlock();
		wr(8'h04, 16'hFFFF);
		`CHK("unlock", 1'b1, nvm_write_unlock)
		chk_rd(8'h04, 16'h8000);
		wr(8'h08, 16'hA5A5);
		`CHK("busy prog", 1'b1, nvm_busy)
		chk_rd(8'h04, 16'hC000);
		wait_idle();
		wr(8'h03, 16'hFF00);
		wait_idle();
		wr(8'h04, 16'h0000);
		do_reset(1'b0, 16'hFF00);
		chk_rd(8'h08, 16'hA5A5);
	endtask

	// Offset, saturation and signed alert compares
	task automatic t_result();
		wr(8'h07, 16'h0100);
		res(16'h7F80, 16'h7FFF);
		`CHK("high_alert", 1'b1, high_alert)
		@(posedge clk);
		flag_clear <= 1'b1;
		@(posedge clk);
		flag_clear <= 1'b0;
		res(16'h0000, 16'h0100);
		`CHK("low clear", 1'b0, low_alert)
		`CHK("high clear", 1'b0, high_alert)
		wr(8'h07, 16'hFF00);
		res(16'h8010, 16'h8000);
		`CHK("low_alert", 1'b1, low_alert)
		// Therm mode: this block must leave both flags alone
		@(posedge clk);
		flag_clear <= 1'b1;
		therm_mode <= 1'b1;
		@(posedge clk);
		flag_clear <= 1'b0;
		res(16'h8010, 16'h8000);
		`CHK("therm low", 1'b0, low_alert)
		res(16'h7F80, 16'h7E80);
		`CHK("therm high", 1'b0, high_alert)
		@(posedge clk);
		therm_mode <= 1'b0;
	endtask

	initial begin
		do_reset(1'b1, 16'h8000);
		t_map();
		t_locked();
		t_unlock();
		t_result();
		final_report();
	end
endmodule
